//--- rtl/t1_rx_frame_sync_control.sv
`timescale 1ns/1ps
`default_nettype none
module t1_rx_frame_sync_control (
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire t1_sync_pkg::host_req_t    host,
  output logic [7:0]                     host_rdata,
  input  wire t1_sync_pkg::rx_bit_t      rx,
  input  wire logic                      carrier_loss,
  output t1_sync_pkg::sync_status_t      status
);

  typedef struct packed {
    logic [7:0]                 ctrl;
    logic                       fmt_esf;
    logic                       resync_prev;
    logic                       carrier_prev;
    t1_sync_pkg::search_state_t state;
    logic [7:0]                 bitpos;
    logic [4:0]                 idx;
    logic [4:0]                 tries;
    logic [4:0]                 qual;
    logic                       stage_b;
    logic [5:0]                 err_hist;
    logic                       crc_restart;
    logic                       fbit;
    logic [7:0]                 rdata;
  } sync_ctl_t;

  sync_ctl_t s_q;
  sync_ctl_t s_d;
  logic      crc_valid;
  logic      crc_ok;

  // Returns {care, expected value} of the framing bit of frame idx; mode 0 Ft only, 1 all D4 bits.
  function automatic logic [1:0] frame_expect(input logic esf, input logic all_bits, input logic [4:0] idx);
    logic [2:0] k;
    k = idx[4:2];
    if (esf) begin
      frame_expect = {idx[1:0] == 2'h3, FPS_PATTERN_BIT(k)};
    end else begin
      frame_expect = {all_bits | ~idx[0], t1_sync_pkg::D4_PATTERN[idx[3:0]]};
    end
  endfunction

  function automatic logic FPS_PATTERN_BIT(input logic [2:0] k);
    FPS_PATTERN_BIT = (k > 3'h5) ? 1'b0 : t1_sync_pkg::FPS_PATTERN[k];
  endfunction

  function automatic logic [4:0] idx_add(input logic [4:0] idx, input logic [4:0] k, input logic esf);
    logic [5:0] sum;
    logic [5:0] per;
    per     = {1'b0, esf ? t1_sync_pkg::ESF_FRAMES : t1_sync_pkg::D4_FRAMES};
    sum     = {1'b0, idx} + {1'b0, k};
    idx_add = (sum >= per) ? 5'(sum - per) : sum[4:0];
  endfunction

  function automatic logic frame_lost(input logic [5:0] hist, input logic [1:0] code);
    logic [5:0] win;
    logic [2:0] cnt;
    win = (code == 2'h0) ? t1_sync_pkg::WINDOW_4 : (code == 2'h1) ? t1_sync_pkg::WINDOW_5 : t1_sync_pkg::WINDOW_6;
    cnt = 3'h0;
    for (int i = 0; i < 6; i++) begin
      cnt = cnt + {2'h0, hist[i] & win[i]};
    end
    frame_lost = cnt >= t1_sync_pkg::LOSS_ERRORS;
  endfunction

  always_comb begin
    logic       trig;
    logic       carrier_evt;
    logic       fbit;
    logic       d4_all;
    logic [1:0] exp_s;
    logic [1:0] exp_m;
    logic       mism;
    logic [4:0] qlen;
    logic [4:0] period;
    logic [1:0] loss_code;
    logic [5:0] hist;
    s_d             = s_q;
    s_d.crc_restart = 1'b0;
    trig            = s_q.ctrl[t1_sync_pkg::RESYNC_BIT] & ~s_q.resync_prev; // [RULE_01]
    carrier_evt     = carrier_loss & ~s_q.carrier_prev;
    fbit            = rx.valid && (s_q.bitpos == 8'h00);
    d4_all          = s_q.ctrl[t1_sync_pkg::CRITERIA_BIT] | s_q.stage_b; // [RULE_04]
    exp_s           = frame_expect(s_q.fmt_esf, d4_all, s_q.idx); // [RULE_09]
    exp_m           = frame_expect(s_q.fmt_esf, 1'b0, s_q.idx);
    mism            = rx.data != exp_s[0];
    qlen            = s_q.ctrl[t1_sync_pkg::QUAL_LEN_BIT] ? t1_sync_pkg::QUAL_LONG : t1_sync_pkg::QUAL_SHORT; // [RULE_03]
    period          = s_q.fmt_esf ? t1_sync_pkg::ESF_FRAMES : t1_sync_pkg::D4_FRAMES;
    loss_code       = {s_q.ctrl[t1_sync_pkg::LOSS_MSB_BIT], s_q.ctrl[t1_sync_pkg::LOSS_LSB_BIT]};
    hist            = {s_q.err_hist[4:0], rx.data != exp_m[0]};
    s_d.resync_prev  = s_q.ctrl[t1_sync_pkg::RESYNC_BIT]; // [RULE_10]
    s_d.carrier_prev = carrier_loss;
    s_d.fbit         = fbit;

    if (host.write && host.addr == t1_sync_pkg::CTRL_OFFSET) begin
      s_d.ctrl = host.wdata & t1_sync_pkg::CTRL_WRITE_MASK;
    end
    if (host.write && host.addr == t1_sync_pkg::MODE_OFFSET) begin
      s_d.fmt_esf = host.wdata[t1_sync_pkg::FMT_SELECT_BIT]; // [RULE_09]
    end
    if (host.read) begin
      case (host.addr)
        t1_sync_pkg::CTRL_OFFSET: s_d.rdata = s_q.ctrl;
        t1_sync_pkg::MODE_OFFSET: s_d.rdata = 8'(s_q.fmt_esf) << t1_sync_pkg::FMT_SELECT_BIT;
        default:                  s_d.rdata = 8'h00;
      endcase
    end

    if (rx.valid) begin
      if (s_q.bitpos == t1_sync_pkg::LAST_BIT_POS) begin
        s_d.bitpos = 8'h00;
        s_d.idx    = idx_add(s_q.idx, 5'h01, s_q.fmt_esf);
      end else begin
        s_d.bitpos = s_q.bitpos + 8'h01;
      end
    end

    case (s_q.state)
      t1_sync_pkg::ST_SEARCH: begin
        if (fbit && exp_s[1]) begin
          if (mism) begin
            s_d.qual = 5'h00;
            if (s_q.stage_b && s_q.idx[0]) begin
              s_d.idx = idx_add(s_q.idx, 5'h02, s_q.fmt_esf); // [RULE_04]
            end else if (s_q.stage_b) begin
              s_d.stage_b = 1'b0;
            end else if (s_q.tries + 5'h01 >= period) begin
              s_d.tries  = 5'h00;
              s_d.bitpos = 8'h00;
            end else begin
              s_d.tries = s_q.tries + 5'h01;
              s_d.idx   = idx_add(s_q.idx, 5'h01, s_q.fmt_esf);
            end
          end else if (s_q.qual + 5'h01 < qlen) begin
            s_d.qual = s_q.qual + 5'h01; // [RULE_03]
          end else begin
            s_d.qual  = 5'h00;
            s_d.tries = 5'h00;
            if (!s_q.fmt_esf && !s_q.ctrl[t1_sync_pkg::CRITERIA_BIT] && !s_q.stage_b) begin
              s_d.stage_b = 1'b1; // [RULE_04]
            end else if (s_q.fmt_esf && s_q.ctrl[t1_sync_pkg::CRITERIA_BIT]) begin
              s_d.state       = t1_sync_pkg::ST_VERIFY; // [RULE_05]
              s_d.crc_restart = 1'b1;
            end else begin
              s_d.state    = t1_sync_pkg::ST_SYNC; // [RULE_05]
              s_d.err_hist = 6'h00;
            end
          end
        end
      end
      t1_sync_pkg::ST_VERIFY: begin
        if (crc_valid && crc_ok) begin
          s_d.state    = t1_sync_pkg::ST_SYNC; // [RULE_05]
          s_d.err_hist = 6'h00;
        end else if (crc_valid && s_q.qual != 5'h00) begin
          s_d.state = t1_sync_pkg::ST_SEARCH;
          s_d.qual  = 5'h00;
          s_d.idx   = idx_add(s_q.idx, 5'h01, s_q.fmt_esf);
        end else if (crc_valid) begin
          s_d.qual = 5'h01;
        end
      end
      t1_sync_pkg::ST_SYNC: begin
        if (fbit && exp_m[1]) begin
          s_d.err_hist = hist;
          if (frame_lost(hist, loss_code)) begin // [RULE_06]
            s_d.state = s_q.ctrl[t1_sync_pkg::AUTO_DIS_BIT] ? t1_sync_pkg::ST_LOST : t1_sync_pkg::ST_SEARCH; // [RULE_02]
          end
        end
        if (carrier_evt && !s_q.ctrl[t1_sync_pkg::TRIG_SEL_BIT] && !s_q.ctrl[t1_sync_pkg::AUTO_DIS_BIT]) begin
          s_d.state = t1_sync_pkg::ST_SEARCH; // [RULE_07] [RULE_08]
        end
      end
      t1_sync_pkg::ST_LOST: begin
        s_d.state = t1_sync_pkg::ST_LOST; // [RULE_02]
      end
      default: begin
        s_d.state = t1_sync_pkg::ST_SEARCH;
      end
    endcase

    if (s_d.state == t1_sync_pkg::ST_SEARCH && s_q.state != t1_sync_pkg::ST_SEARCH) begin
      s_d.qual    = 5'h00;
      s_d.tries   = 5'h00;
      s_d.stage_b = 1'b0;
    end
    if (trig) begin
      s_d.state   = t1_sync_pkg::ST_SEARCH; // [RULE_01]
      s_d.qual    = 5'h00;
      s_d.tries   = 5'h00;
      s_d.stage_b = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q       <= '0;
      s_q.ctrl  <= t1_sync_pkg::CTRL_RESET;
      s_q.fmt_esf <= t1_sync_pkg::MODE_RESET;
      s_q.state <= t1_sync_pkg::ST_SEARCH;
    end else begin
      s_q <= s_d;
    end
  end

  t1_crc6_check u_crc (
    .clock       (clock),
    .resetn      (resetn),
    .restart     (s_q.crc_restart),
    .bit_valid   (rx.valid),
    .bit_data    (rx.data),
    .is_fbit     (s_q.bitpos == 8'h00),
    .crc_slot    (s_q.bitpos == 8'h00 && s_q.idx[1:0] == 2'h1),
    .sf_end      (s_q.bitpos == t1_sync_pkg::LAST_BIT_POS && s_q.idx == 5'h17),
    .check_valid (crc_valid),
    .check_ok    (crc_ok)
  );

  assign host_rdata          = s_q.rdata;
  assign status.in_sync      = s_q.state == t1_sync_pkg::ST_SYNC;
  assign status.out_of_frame = s_q.state != t1_sync_pkg::ST_SYNC;
  assign status.searching    = s_q.state == t1_sync_pkg::ST_SEARCH || s_q.state == t1_sync_pkg::ST_VERIFY;
  assign status.fbit         = s_q.fbit;
  assign status.frame_index  = s_q.idx;

endmodule
`default_nettype wire

//--- rtl/t1_sync_pkg.sv
// What this block does
// [RULE_01] A rise of the resync bit from 0 to 1 starts one new alignment search; holding it at 1 starts nothing more.
// [RULE_02] With the auto-realign-disable bit at 0 the framer realigns by itself after losing frame; at 1 only the resync bit does.
// [RULE_03] A candidate alignment must match on 10 framing bits with the qualify-length bit at 0 and on 24 with it at 1.
// [RULE_04] In D4 with the search-criteria bit at 0 the framer locks Ft first and then Fs; at 1 it checks Ft and Fs together.
// [RULE_05] In ESF with the search-criteria bit at 0 alignment rests on FPS alone; at 1 it is also confirmed by the CRC6 check.
// [RULE_06] Out of frame is declared at 2 errors in 4, 5 or 6 framing bits for criteria codes 00, 01 and 1x.
// [RULE_07] With the trigger-select bit at 0 an automatic realign starts on out of frame or on a carrier loss event.
// [RULE_08] With the trigger-select bit at 1 only out of frame starts an automatic realign, never carrier loss alone.
// [RULE_09] The framing format bit picks D4 superframe at 0 and ESF extended superframe at 1.
// [RULE_10] The resync rise is detected in the framer clock domain so one write gives exactly one search.
package t1_sync_pkg;

  localparam logic [7:0] CTRL_OFFSET     = 8'h03;
  localparam logic [7:0] MODE_OFFSET     = 8'h04;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h7f;
  localparam logic       MODE_RESET      = 1'b0;

  localparam int RESYNC_BIT     = 0;
  localparam int AUTO_DIS_BIT   = 1;
  localparam int QUAL_LEN_BIT   = 2;
  localparam int CRITERIA_BIT   = 3;
  localparam int LOSS_MSB_BIT   = 4;
  localparam int LOSS_LSB_BIT   = 5;
  localparam int TRIG_SEL_BIT   = 6;
  localparam int FMT_SELECT_BIT = 6;

  localparam logic [4:0]  QUAL_SHORT   = 5'h0a;
  localparam logic [4:0]  QUAL_LONG    = 5'h18;
  localparam logic [7:0]  LAST_BIT_POS = 8'hc0;
  localparam logic [4:0]  D4_FRAMES    = 5'h0c;
  localparam logic [4:0]  ESF_FRAMES   = 5'h18;
  localparam logic [11:0] D4_PATTERN   = 12'h3b1;
  localparam logic [5:0]  FPS_PATTERN  = 6'h34;
  localparam logic [5:0]  CRC_POLY     = 6'h03;
  localparam logic [5:0]  WINDOW_4     = 6'h0f;
  localparam logic [5:0]  WINDOW_5     = 6'h1f;
  localparam logic [5:0]  WINDOW_6     = 6'h3f;
  localparam logic [2:0]  LOSS_ERRORS  = 3'h2;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic valid;
    logic data;
  } rx_bit_t;

  typedef struct packed {
    logic       in_sync;
    logic       out_of_frame;
    logic       searching;
    logic       fbit;
    logic [4:0] frame_index;
  } sync_status_t;

  typedef enum logic [1:0] {
    ST_SEARCH,
    ST_VERIFY,
    ST_SYNC,
    ST_LOST
  } search_state_t;

endpackage

//--- rtl/t1_crc6_check.sv
`timescale 1ns/1ps
`default_nettype none
module t1_crc6_check (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic restart,
  input  wire logic bit_valid,
  input  wire logic bit_data,
  input  wire logic is_fbit,
  input  wire logic crc_slot,
  input  wire logic sf_end,
  output logic      check_valid,
  output logic      check_ok
);

  typedef struct packed {
    logic [5:0] rem;
    logic [5:0] prev_rem;
    logic [5:0] rx_crc;
    logic       primed;
    logic       valid;
    logic       ok;
  } crc_state_t;

  crc_state_t s_q;
  crc_state_t s_d;

  function automatic logic [5:0] crc_step(input logic [5:0] r, input logic d);
    logic fb;
    fb       = d ^ r[5];
    crc_step = {r[4:0], 1'b0} ^ ({6{fb}} & t1_sync_pkg::CRC_POLY);
  endfunction

  always_comb begin
    logic [5:0] r_next;
    r_next        = crc_step(s_q.rem, is_fbit | bit_data);
    s_d           = s_q;
    s_d.valid     = 1'b0;
    if (restart) begin
      s_d = '0;
    end else if (bit_valid) begin
      s_d.rem = r_next;
      if (crc_slot) begin
        s_d.rx_crc = {s_q.rx_crc[4:0], bit_data};
      end
      if (sf_end) begin
        // Bits received in this superframe check the remainder of the one before.
        s_d.valid    = 1'b1;
        s_d.ok       = s_q.primed && (s_q.rx_crc == s_q.prev_rem);
        s_d.prev_rem = r_next;
        s_d.rem      = '0;
        s_d.primed   = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign check_valid = s_q.valid;
  assign check_ok    = s_q.ok;

endmodule
`default_nettype wire

//--- bench/t1_sync_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module t1_sync_assertions (
  input wire logic                      clock,
  input wire logic                      resetn,
  input wire t1_sync_pkg::host_req_t    host,
  input wire logic [7:0]                host_rdata,
  input wire t1_sync_pkg::rx_bit_t      rx,
  input wire logic                      carrier_loss,
  input wire t1_sync_pkg::sync_status_t status
);
  logic [7:0] ctrl_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= 8'h00;
    end else if (host.write && host.addr == 8'h03) begin
      ctrl_q <= host.wdata & 8'h7f;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  sequence rise_s;
    $rose(ctrl_q[0]);
  endsequence
  sequence loss_s;
    status.in_sync && $rose(carrier_loss) && !$rose(ctrl_q[0]);
  endsequence
  resync_search_a: assert property (rise_s |=> status.searching)
    else $error("resync rise did not start a search");
  // The write that raises the resync bit is taken on the edge before the rise is sampled.
  manual_only_a: assert property (
    ctrl_q[1] && !status.in_sync && !status.searching && !$rose(ctrl_q[0]) |=>
      !status.searching || $rose(ctrl_q[0]))
    else $error("search restarted without resync");
  oof_level_a: assert property (status.out_of_frame == !status.in_sync)
    else $error("out of frame not the inverse of sync");
  sync_on_bit_a: assert property ($rose(status.in_sync) |-> $past(rx.valid))
    else $error("sync declared without a received bit");
  loss_ignored_a: assert property (loss_s ##0 ctrl_q[6] ##1 !status.fbit |-> status.in_sync)
    else $error("carrier loss alone dropped sync");
  loss_restart_a: assert property (
    loss_s ##0 !ctrl_q[6] && !ctrl_q[1] |-> ##[1:2] status.searching)
    else $error("carrier loss did not restart search");
  rd_control_a: assert property (host.read && host.addr == 8'h03 |=> host_rdata == $past(ctrl_q))
    else $error("control readback wrong");
  rd_unmapped_a: assert property (
    host.read && host.addr != 8'h03 && host.addr != 8'h04 |=> host_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind t1_rx_frame_sync_control t1_sync_assertions u_t1_sync_assertions (.clock(clock), .resetn(resetn),
  .host(host), .host_rdata(host_rdata), .rx(rx), .carrier_loss(carrier_loss), .status(status));
`default_nettype wire

//--- bench/t1_stream_src.sv
`timescale 1ns/1ps
`default_nettype none
module t1_stream_src (
  input  wire logic            clock,
  input  wire logic            resetn,
  input  wire logic            esf,
  input  wire logic [2:0]      gap,
  output t1_sync_pkg::rx_bit_t rx
);
  logic [7:0] bit_q;
  logic [4:0] frm_q;
  logic [2:0] cnt_q;
  logic       chk_f;
  logic       f_val;
  always_comb begin
    chk_f = esf ? (frm_q[1:0] == 2'h3) : !frm_q[0];
    f_val = esf ? (!chk_f || t1_sync_pkg::FPS_PATTERN[frm_q[4:2]])
                : t1_sync_pkg::D4_PATTERN[frm_q % 5'h0c];
    rx.valid = resetn;
    rx.data = (bit_q == 8'h00) && (f_val ^ (chk_f && gap != 3'h0 && cnt_q == gap - 3'h1));
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_q <= 8'h00;
      frm_q <= 5'h00;
      cnt_q <= 3'h0;
    end else begin
      bit_q <= (bit_q == 8'hc0) ? 8'h00 : bit_q + 8'h01;
      if (bit_q == 8'hc0) begin
        frm_q <= (frm_q >= (esf ? 5'h17 : 5'h0b)) ? 5'h00 : frm_q + 5'h01;
      end
      if (bit_q == 8'h00 && chk_f) begin
        cnt_q <= (cnt_q + 3'h1 >= gap) ? 3'h0 : cnt_q + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/t1_rx_frame_sync_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module t1_rx_frame_sync_control_tb;
  logic                      clock = 1'b0;
  logic                      resetn = 1'b0;
  t1_sync_pkg::host_req_t    host = '0;
  logic [7:0]                host_rdata;
  t1_sync_pkg::rx_bit_t      rx;
  logic                      carrier_loss = 1'b0;
  t1_sync_pkg::sync_status_t status;
  logic                      esf = 1'b0;
  logic [2:0]                gap = 3'h0;
  int                        fail_count = 0;
  int                        num_checks = 0;
  int                        n0, n1;
  always #12.5 clock = ~clock;
  t1_rx_frame_sync_control u_t1_rx_frame_sync_control (.clock(clock), .resetn(resetn), .host(host),
    .host_rdata(host_rdata), .rx(rx), .carrier_loss(carrier_loss), .status(status));
  t1_stream_src u_t1_stream_src (.clock(clock), .resetn(resetn), .esf(esf), .gap(gap), .rx(rx));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    host <= {1'b1, 1'b0, a, d};
    @(posedge clock);
    host <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    host <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    host <= '0;
    @(negedge clock);
    chk(host_rdata, e);
  endtask
  task automatic wait_sync(input logic v);
    for (n0 = 0; n0 < 40000 && status.in_sync !== v; n0++) @(negedge clock);
    if (n0 == 40000) begin
      fail_count++;
      $display("[ERR] %0t sync wait ran out", $time);
      wrap_up;
    end
  endtask
  task automatic sync(input logic [7:0] c);
    wr(8'h03, c & 8'hfe);
    wr(8'h03, c | 8'h01);
    @(posedge clock);
    @(negedge clock);
    wait_sync(1'b1);
  endtask
  task automatic t_reg;
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h03, 8'hfe);
    rd(8'h03, 8'h7e);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'h40);
    wr(8'h04, 8'h00);
    wr(8'h03, 8'h00);
    $display("register test done");
  endtask
  task automatic t_qual;
    sync(8'h08);
    n1 = n0;
    sync(8'h0c);
    chk(n0 > n1 + 16'h0182, 1'b1);
    sync(8'h00);
    chk(n0 > n1 + 16'h03c5, 1'b1);
    wr(8'h03, 8'h01);
    repeat (6) @(negedge clock);
    chk(status.in_sync, 1'b1);
    for (n1 = 0; n1 < 400 && status.fbit !== 1'b1; n1++) @(negedge clock);
    chk(u_t1_stream_src.bit_q, 8'h01);
    chk(status.frame_index, u_t1_stream_src.frm_q);
    $display("qualify test done");
  endtask
  task automatic t_oof;
    logic [7:0] tab [7] = '{8'h04, 8'h0b, 8'h45, 8'h4c, 8'hc6, 8'hcd, 8'h8d};
    logic [7:0] e;
    for (int i = 0; i < 7; i++) begin
      e = tab[i];
      sync({2'b00, e[6], e[7], 4'ha});
      @(posedge clock);
      gap <= e[2:0];
      for (n1 = 0; n1 < 16'h0400 * e[2:0] && status.in_sync === 1'b1; n1++) @(negedge clock);
      chk(status.in_sync, !e[3]);
      @(posedge clock);
      gap <= 3'h0;
      repeat (400) @(negedge clock);
      chk(status.searching, 1'b0);
    end
    $display("frame loss test done");
  endtask
  task automatic t_loss;
    sync(8'h48);
    @(posedge clock);
    carrier_loss <= 1'b1;
    repeat (8) @(negedge clock);
    chk(status.in_sync, 1'b1);
    @(posedge clock);
    carrier_loss <= 1'b0;
    wr(8'h03, 8'h08);
    @(posedge clock);
    carrier_loss <= 1'b1;
    repeat (3) @(negedge clock);
    chk(status.searching, 1'b1);
    @(posedge clock);
    carrier_loss <= 1'b0;
    wait_sync(1'b1);
    @(posedge clock);
    gap <= 3'h1;
    wait_sync(1'b0);
    @(posedge clock);
    gap <= 3'h0;
    wait_sync(1'b1);
    chk(status.in_sync, 1'b1);
    $display("carrier loss test done");
  endtask
  task automatic t_esf;
    wr(8'h04, 8'h40);
    esf <= 1'b1;
    sync(8'h00);
    chk(status.in_sync, 1'b1);
    sync(8'h08 & 8'h00);
    wr(8'h03, 8'h08);
    wr(8'h03, 8'h09);
    @(posedge clock);
    @(negedge clock);
    for (n0 = 0; n0 < 20000 && status.in_sync !== 1'b1; n0++) @(negedge clock);
    chk(status.in_sync, 1'b0);
    $display("extended superframe test done");
  endtask
  initial begin
    repeat (12) @(posedge clock);
    chk(status, 16'h00c0);
    chk(host_rdata, 8'h00);
    resetn <= 1'b1;
    t_reg;
    t_qual;
    t_oof;
    t_loss;
    t_esf;
    wrap_up;
  end
endmodule
`default_nettype wire
